// *** testbench/dcr_host_model.sv ***
// Purpose: host model that writes register words into the slice
// Assumes: one write request per call, one idle edge after each
// Notes: bits outside the mask carry the default map word
`timescale 1ns/1ps
module dcr_host_model (
  input wire logic i_clock,
  output dcr_pkg::dcr_wr_req_type o_wr
);
  initial o_wr = '0;
  task automatic put(input logic [6:0] a, input logic [15:0] base,
      input logic [15:0] mask, input logic [15:0] f);
    @(posedge i_clock);
    o_wr <= {1'b1, a, (base & ~mask) | (f & mask)};
    @(posedge i_clock);
    o_wr.valid <= 1'b0;
  endtask
endmodule

// *** testbench/dcr_properties.sv ***
// Purpose: port-level checks of the divider config register slice
// Assumes: decoded outputs follow a stored word by one enabled edge
// Notes: a write is judged only when the next edge is enabled too
`timescale 1ns/1ps
`include "dcr_defines.svh"
module dcr_properties (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_clock_en,
  input wire dcr_pkg::dcr_wr_req_type i_wr,
  input wire logic [`DCR_ADDR_W-1:0] i_rd_addr,
  input wire logic [`DCR_DATA_W-1:0] o_rd_data,
  input wire logic o_rd_hit,
  input wire dcr_pkg::dcr_chain_type o_chain,
  input wire dcr_pkg::dcr_feedback_type o_feedback
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  logic [15:0] d1_q;
  logic [15:0] d2_q;
  // write data two edges back lines up with the decoded result
  always_ff @(posedge i_clock) begin
    d1_q <= i_wr.data;
    d2_q <= d1_q;
  end
  function automatic logic [3:0] hot(input logic [3:0] c);
    case (c)
      4'h1: hot = 4'h2;
      4'h2: hot = 4'h4;
      4'h4: hot = 4'h6;
      4'h8: hot = 4'h8;
      default: hot = 4'h0;
    endcase
  endfunction
  sequence s_wr(logic [6:0] a);
    i_clock_en && i_wr.valid && i_wr.addr == a ##1 i_clock_en;
  endsequence
  AST_CHAIN_EN: assert property (s_wr(7'h22) |=>
    o_chain.enable_all == d2_q[5]) else $error("master enable wrong");
  AST_S1_RATIO: assert property (s_wr(7'h23) |=>
    o_chain.stage_one_ratio == (d2_q[2] ? 4'h3 : 4'h2))
    else $error("stage one ratio wrong");
  AST_S2_RATIO: assert property (s_wr(7'h23) |=>
    o_chain.stage_two_ratio == hot(d2_q[12:9]))
    else $error("stage two ratio wrong");
  AST_S3_RATIO: assert property (s_wr(7'h24) |=>
    o_chain.stage_three_ratio == hot(d2_q[3:0]))
    else $error("stage three ratio wrong");
  AST_PRESC: assert property (s_wr(7'h25) |=>
    o_feedback.prescaler_ratio == (d2_q[12] ? 3'h4 : 3'h2))
    else $error("prescaler ratio wrong");
  AST_INTEG: assert property (s_wr(7'h26) |=>
    o_feedback.integer_part == d2_q[12:1]) else $error("integer wrong");
  AST_OUT_A: assert property (o_chain.out_a_divided |->
    o_chain.active && !o_chain.out_a_from_osc) else $error("out a wrong");
  AST_MASTER_OFF: assert property (!o_chain.enable_all |->
    !o_chain.active && o_chain.total_ratio == 8'h00)
    else $error("chain runs while disabled");
  AST_TOTAL: assert property (o_chain.active &&
    o_chain.stage_on == 3'h1 |-> o_chain.total_ratio ==
    {4'h0, o_chain.stage_one_ratio}) else $error("total ratio wrong");
  AST_READ: assert property (i_clock_en |=> o_rd_hit ==
    ($past(i_rd_addr) inside {[7'h1F:7'h2D], 7'h2F, 7'h30}))
    else $error("read hit wrong");
endmodule
bind dcr_divider_config dcr_properties i_props (.i_clock(i_clock),
  .i_reset_n(i_reset_n), .i_clock_en(i_clock_en), .i_wr(i_wr),
  .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data), .o_rd_hit(o_rd_hit),
  .o_chain(o_chain), .o_feedback(o_feedback));

// *** testbench/tb_dcr_divider_config.sv ***
// Purpose: directed scenarios for the divider config register slice
// Assumes: host model owns the write port, bench owns read and enable
// Notes: decoded outputs are sampled one edge after the write lands
`timescale 1ns/1ps
module tb_dcr_divider_config;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_clock_en = 1'b1;
  logic [6:0] i_rd_addr = 7'h00;
  logic [15:0] o_rd_data;
  logic o_rd_hit;
  dcr_pkg::dcr_wr_req_type i_wr;
  dcr_pkg::dcr_chain_type o_chain;
  dcr_pkg::dcr_feedback_type o_feedback;
  int err_total = 0;
  int n_checks = 0;
  always #5 i_clock = ~i_clock;
  dcr_host_model i_host (.i_clock(i_clock), .o_wr(i_wr));
  dcr_divider_config i_dut (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_clock_en(i_clock_en), .i_wr(i_wr), .i_rd_addr(i_rd_addr),
    .o_rd_data(o_rd_data), .o_rd_hit(o_rd_hit), .o_chain(o_chain),
    .o_feedback(o_feedback));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic w(input logic [6:0] a, input logic [15:0] base,
      input logic [15:0] mask, input logic [15:0] f);
    i_host.put(a, base, mask, f);
    // the word lands at the last edge of put; decode follows one edge later
    @(posedge i_clock);
    @(negedge i_clock);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] d, input logic h);
    @(posedge i_clock);
    i_rd_addr <= a;
    @(posedge i_clock);
    @(negedge i_clock);
    check(o_rd_data, d);
    check(o_rd_hit, h);
  endtask
  task automatic t_reset();
    logic [22:0] tb [11] = '{{7'h22, 16'h0020}, {7'h23, 16'h0204},
      {7'h24, 16'h0411}, {7'h25, 16'h0000}, {7'h26, 16'h0036},
      {7'h27, 16'h0000}, {7'h28, 16'h03E8}, {7'h29, 16'h03E8},
      {7'h2A, 16'h0000}, {7'h2D, 16'h0000}, {7'h2E, 16'h0000}};
    foreach (tb[i]) begin
      rd(tb[i][22:16], tb[i][15:0], tb[i][22:16] != 7'h2E);
    end
    check(o_chain.enable_all, 1'b1);
    check(o_feedback.integer_part, 12'h01B);
    check(o_feedback.denominator, 32'h03E803E8);
    w(7'h20, 16'h0000, 16'h0000, 16'hFFFF);
    rd(7'h20, 16'h0000, 1'b1);
  endtask
  task automatic t_chain();
    logic [3:0] rt [4] = '{4'h2, 4'h4, 4'h6, 4'h8};
    logic [3:0] r1;
    logic [7:0] tot;
    logic [2:0] sel;
    for (int i = 0; i < 4; i++) begin
      r1 = i[0] ? 4'h3 : 4'h2;
      sel = (i == 0) ? 3'h1 : (i == 1) ? 3'h2 : 3'h4;
      tot = (i == 0) ? r1 : (i == 1) ? r1 * rt[i] : r1 * rt[i] * rt[3-i];
      w(7'h23, 16'h0204, 16'h1F86, {3'h0, 4'h1 << i, 2'h3, 4'h0, i[0], 2'h2});
      w(7'h24, 16'h0411, 16'h007F, {9'h0, sel, 4'h1 << (3 - i)});
      check(o_chain.stage_one_ratio, r1);
      check(o_chain.stage_two_ratio, rt[i]);
      check(o_chain.stage_three_ratio, rt[3-i]);
      check(o_chain.stage_on, (sel << 1) - 3'h1);
      check(o_chain.total_ratio, tot);
      check(o_chain.active, 1'b1);
    end
    w(7'h23, 16'h0204, 16'hFFFF, 16'h1106);
    check({o_chain.active, o_chain.total_ratio}, 9'h000);
    w(7'h23, 16'h0204, 16'hFFFF, 16'h0186);
    check(o_chain.stage_two_ratio, 4'h0);
    w(7'h24, 16'h0411, 16'h007F, 16'h0011);
    w(7'h22, 16'h0020, 16'h0020, 16'h0000);
    check({o_chain.enable_all, o_chain.active}, 2'h0);
    w(7'h22, 16'h0020, 16'h0020, 16'h0020);
    check(o_chain.active, 1'b1);
  endtask
  task automatic t_outputs();
    check(o_chain.out_a_divided, 1'b1);
    check(o_chain.out_b_divided, 1'b0);
    w(7'h24, 16'h0411, 16'h0800, 16'h0800);
    check(o_chain.out_b_divided, 1'b1);
    w(7'h2F, 16'h0000, 16'h1800, 16'h0800);
    check({o_chain.out_a_from_osc, o_chain.out_a_divided}, 2'h2);
    w(7'h1F, 16'h0000, 16'h0080, 16'h0080);
    check({o_chain.input_buf_on, o_chain.active}, 2'h0);
    w(7'h1F, 16'h0000, 16'h0080, 16'h0000);
    check(o_chain.active, 1'b1);
    w(7'h30, 16'h0000, 16'h0003, 16'h0001);
    check({o_chain.out_b_from_osc, o_chain.out_b_divided}, 2'h2);
    rd(7'h30, 16'h0001, 1'b1);
    rd(7'h24, 16'h0C11, 1'b1);
  endtask
  task automatic t_rereset();
    @(posedge i_clock);
    i_reset_n <= 1'b0;
    @(posedge i_clock);
    i_reset_n <= 1'b1;
    rd(7'h2B, 16'h0000, 1'b1);
    rd(7'h24, 16'h0411, 1'b1);
    check({o_chain.active, o_feedback.integer_part}, 13'h001B);
  endtask
  task automatic t_feedback();
    logic [4:0] cy [5] = '{5'h04, 5'h06, 5'h08, 5'h0C, 5'h10};
    w(7'h25, 16'h0000, 16'h1000, 16'h1000);
    check(o_feedback.prescaler_ratio, 3'h4);
    w(7'h26, 16'h0036, 16'h1FFE, 16'h1FFE);
    check(o_feedback.integer_part, 12'hFFF);
    for (int i = 0; i < 6; i++) begin
      w(7'h27, 16'h0000, 16'h3F00, 16'h0100 << i);
      check(o_feedback.pfd_delay_valid, i < 5);
      if (i < 5) begin
        check(o_feedback.pfd_delay_cycles, cy[i]);
      end
    end
    w(7'h2C, 16'h0000, 16'hFFFF, 16'h1234);
    check(o_feedback.numerator, 32'h12340000);
    w(7'h2D, 16'h0000, 16'hFFFF, 16'h5678);
    check(o_feedback.numerator, 32'h12345678);
    w(7'h28, 16'h03E8, 16'hFFFF, 16'h0000);
    check(o_feedback.denominator, 32'h000003E8);
    w(7'h29, 16'h03E8, 16'hFFFF, 16'h0000);
    check(o_feedback.fraction_valid, 1'b0);
    w(7'h2A, 16'h0000, 16'hFFFF, 16'hBEEF);
    w(7'h2B, 16'h0000, 16'hFFFF, 16'hCAFE);
    check(o_feedback.seed, 32'hBEEFCAFE);
    // a frozen clock enable must drop the write entirely
    @(posedge i_clock);
    i_clock_en <= 1'b0;
    w(7'h2B, 16'h0000, 16'hFFFF, 16'h0000);
    @(posedge i_clock);
    i_clock_en <= 1'b1;
    rd(7'h2B, 16'hCAFE, 1'b1);
  endtask
  task automatic stop_test();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_clock);
    i_reset_n <= 1'b1;
    t_reset();
    t_chain();
    t_outputs();
    t_feedback();
    t_rereset();
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge i_clock);
    err_total++;
    stop_test();
  end
endmodule

// *** verilog/dcr_defines.svh ***
// Purpose: register addresses, field positions, reset words, decode values
// Assumes: 7-bit register address, 16-bit register words
// Notes: reserved bits reset to zero; the host owns their real values
`ifndef DCR_DEFINES_SVH
`define DCR_DEFINES_SVH

`define DCR_ADDR_W 7
`define DCR_DATA_W 16

// register addresses
`define DCR_ADDR_INBUF 7'h1F
`define DCR_ADDR_RSV_A 7'h20
`define DCR_ADDR_RSV_B 7'h21
`define DCR_ADDR_MASTER 7'h22
`define DCR_ADDR_STAGE 7'h23
`define DCR_ADDR_SELBUF 7'h24
`define DCR_ADDR_PRESC 7'h25
`define DCR_ADDR_INTEG 7'h26
`define DCR_ADDR_PFD 7'h27
`define DCR_ADDR_DEN_HI 7'h28
`define DCR_ADDR_DEN_LO 7'h29
`define DCR_ADDR_SEED_HI 7'h2A
`define DCR_ADDR_SEED_LO 7'h2B
`define DCR_ADDR_NUM_HI 7'h2C
`define DCR_ADDR_NUM_LO 7'h2D
`define DCR_ADDR_OUTA_SRC 7'h2F
`define DCR_ADDR_OUTB_SRC 7'h30

// field positions
`define DCR_BIT_INBUF_PD 7
`define DCR_BIT_CHAIN_EN 5
`define DCR_MSB_S2_RATIO 12
`define DCR_LSB_S2_RATIO 9
`define DCR_BIT_S3_EN 8
`define DCR_BIT_S2_EN 7
`define DCR_BIT_S1_RATIO 2
`define DCR_BIT_S1_EN 1
`define DCR_BIT_OUTB_EN 11
`define DCR_BIT_OUTA_EN 10
`define DCR_MSB_SEL 6
`define DCR_LSB_SEL 4
`define DCR_MSB_S3_RATIO 3
`define DCR_LSB_S3_RATIO 0
`define DCR_BIT_PRESC 12
`define DCR_MSB_INTEG 12
`define DCR_LSB_INTEG 1
`define DCR_MSB_PFD 13
`define DCR_LSB_PFD 8
`define DCR_MSB_OUTA_SRC 12
`define DCR_LSB_OUTA_SRC 11
`define DCR_MSB_OUTB_SRC 1
`define DCR_LSB_OUTB_SRC 0

// reset words
`define DCR_RST_ZERO 16'h0000
`define DCR_RST_MASTER 16'h0020
`define DCR_RST_STAGE 16'h0204
`define DCR_RST_SELBUF 16'h0411
`define DCR_RST_INTEG 16'h0036
`define DCR_RST_DEN 16'h03E8

// stage-select codes
`define DCR_SEL_ONE 3'h1
`define DCR_SEL_TWO 3'h2
`define DCR_SEL_THREE 3'h4

// output source codes
`define DCR_SRC_DIVIDER 2'h0
`define DCR_SRC_OSC 2'h1

// prescaler ratios
`define DCR_PRESC_LOW 3'h2
`define DCR_PRESC_HIGH 3'h4

// phase detector delay codes and cycle counts
`define DCR_PFD_C1 6'h01
`define DCR_PFD_C2 6'h02
`define DCR_PFD_C4 6'h04
`define DCR_PFD_C8 6'h08
`define DCR_PFD_C16 6'h10
`define DCR_PFD_D1 5'h04
`define DCR_PFD_D2 5'h06
`define DCR_PFD_D4 5'h08
`define DCR_PFD_D8 5'h0C
`define DCR_PFD_D16 5'h10

`endif

// *** verilog/dcr_divider_config.sv ***
// Purpose: register slice for the output divider chain and feedback divider
// Assumes: serial framing is decoded outside into one-word write requests
// Notes: all outputs are registered; decoded controls lag a write by 1 edge
//   32-bit values are not shadowed: a half-written value shows at once
//   writes outside this slice are ignored; reads of them return zero
// Operation
// - master enable bit 5, default 1, powers the whole divider chain
// - stage two ratio bits 12:9 one-hot: 2,4,6,8, zero powers down
// - stage one ratio bit 2: set divides by 3, clear by 2
// - each stage has own enable bit, default 0, zero powers it down
// - stage select bits 6:4 choose stages one, one-two, one-two-three
// - stage three ratio bits 3:0 use the same one-hot code
// - bit 11, reset 0, enables divided signal buffer to output B
// - bit 10, reset 1, enables divided signal buffer to output A
// - prescaler select bit 12: set divides by 4, clear by 2
// - feedback integer part is 12 bits at 12:1, default 27
// - delay code bits 13:8 give 4,6,8,12,16 cycles; 32 unused
// - 32-bit denominator split high then low, each half default 1000
// - 32-bit numerator split high then low, both default 0
// - 32-bit modulator seed split high then low, both reset 0
// - output source 0 takes divider chain, 1 takes oscillator
// - separate power-down bit removes the divider chain input
`timescale 1ns/1ps
`include "dcr_defines.svh"

module dcr_divider_config (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_clock_en,
  input wire dcr_pkg::dcr_wr_req_type i_wr,
  input wire logic [`DCR_ADDR_W-1:0] i_rd_addr,
  output logic [`DCR_DATA_W-1:0] o_rd_data,
  output logic o_rd_hit,
  output dcr_pkg::dcr_chain_type o_chain,
  output dcr_pkg::dcr_feedback_type o_feedback
);

  dcr_pkg::dcr_state_type state_q;
  dcr_pkg::dcr_state_type state_d;

  // one-hot ratio code of stages two and three; anything else is off
  function automatic logic [3:0] dcr_hot_ratio(input logic [3:0] code);
    logic [3:0] r;
    r = 4'h0;
    unique case (code)
      4'h1: r = 4'h2;
      4'h2: r = 4'h4;
      4'h4: r = 4'h6;
      4'h8: r = 4'h8;
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  // per-stage view of the chain; index 0 is stage one
  logic [2:0] stage_en;
  logic [2:0] stage_used;
  logic [3:0] stage_ratio [3];
  logic [2:0] stage_sel;

  assign stage_sel = state_q.selbuf[`DCR_MSB_SEL:`DCR_LSB_SEL];

  assign stage_en[0] = state_q.stage[`DCR_BIT_S1_EN];
  assign stage_en[1] = state_q.stage[`DCR_BIT_S2_EN];
  assign stage_en[2] = state_q.stage[`DCR_BIT_S3_EN];

  // stage one has no off code: its bit only picks 3 or 2
  assign stage_ratio[0] = state_q.stage[`DCR_BIT_S1_RATIO] ?
                          4'h3 : 4'h2;
  assign stage_ratio[1] = dcr_hot_ratio(
    state_q.stage[`DCR_MSB_S2_RATIO:`DCR_LSB_S2_RATIO]);
  assign stage_ratio[2] = dcr_hot_ratio(
    state_q.selbuf[`DCR_MSB_S3_RATIO:`DCR_LSB_S3_RATIO]);

  // select code 0 or any other code leaves every stage out
  assign stage_used[0] = (stage_sel == `DCR_SEL_ONE) ||
                         (stage_sel == `DCR_SEL_TWO) ||
                         (stage_sel == `DCR_SEL_THREE);
  assign stage_used[1] = (stage_sel == `DCR_SEL_TWO) ||
                         (stage_sel == `DCR_SEL_THREE);
  assign stage_used[2] = (stage_sel == `DCR_SEL_THREE);

  logic chain_en;
  logic input_on;
  logic [2:0] stage_on;
  logic [2:0] stage_ok;

  assign chain_en = state_q.master[`DCR_BIT_CHAIN_EN];
  assign input_on = !state_q.inbuf[`DCR_BIT_INBUF_PD];

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_stage
      // a stage runs only under the master enable and its own enable
      assign stage_on[g] = chain_en && stage_en[g] &&
                           (stage_ratio[g] != 4'h0);
      // a left-out stage does not block the chain
      assign stage_ok[g] = !stage_used[g] || stage_on[g];
    end
  endgenerate

  logic [7:0] r1;
  logic [7:0] r2;
  logic [7:0] r3;
  logic [7:0] total;
  logic chain_active;

  // left-out stages contribute a ratio of one; largest product is 192
  assign r1 = {4'h0, stage_ratio[0]};
  assign r2 = stage_used[1] ? {4'h0, stage_ratio[1]} : 8'h01;
  assign r3 = stage_used[2] ? {4'h0, stage_ratio[2]} : 8'h01;
  assign total = 8'(r1 * r2 * r3);

  assign chain_active = chain_en && input_on && stage_used[0] &&
                        (&stage_ok);

  // both outputs share one routing rule; index 0 is output A, 1 is B
  logic [1:0] out_src [2];
  logic [1:0] out_buf_en;
  logic [1:0] out_divided;
  logic [1:0] out_from_osc;

  assign out_src[0] =
    state_q.outa_src[`DCR_MSB_OUTA_SRC:`DCR_LSB_OUTA_SRC];
  assign out_src[1] =
    state_q.outb_src[`DCR_MSB_OUTB_SRC:`DCR_LSB_OUTB_SRC];
  assign out_buf_en[0] = state_q.selbuf[`DCR_BIT_OUTA_EN];
  assign out_buf_en[1] = state_q.selbuf[`DCR_BIT_OUTB_EN];

  generate
    for (g = 0; g < 2; g++) begin : g_out
      // the divided signal needs a live chain and an open buffer
      assign out_divided[g] = chain_active && out_buf_en[g] &&
                              (out_src[g] == `DCR_SRC_DIVIDER);
      // source codes 2 and 3 are reserved and route neither signal
      assign out_from_osc[g] = (out_src[g] == `DCR_SRC_OSC);
    end
  endgenerate

  logic [5:0] pfd_code;
  logic [4:0] pfd_cycles;
  assign pfd_code = state_q.pfd[`DCR_MSB_PFD:`DCR_LSB_PFD];

  always_comb begin
    pfd_cycles = 5'h00;
    unique case (pfd_code)
      `DCR_PFD_C1: pfd_cycles = `DCR_PFD_D1;
      `DCR_PFD_C2: pfd_cycles = `DCR_PFD_D2;
      `DCR_PFD_C4: pfd_cycles = `DCR_PFD_D4;
      `DCR_PFD_C8: pfd_cycles = `DCR_PFD_D8;
      `DCR_PFD_C16: pfd_cycles = `DCR_PFD_D16;
      // code 32 and every non one-hot code is unused: zero, not valid
      default: pfd_cycles = 5'h00;
    endcase
  end

  always_comb begin
    state_d = state_q;
    // whole words are kept, reserved bits too, so reads echo writes
    if (i_wr.valid) begin
      unique case (i_wr.addr)
        `DCR_ADDR_INBUF: state_d.inbuf = i_wr.data;
        `DCR_ADDR_RSV_A: state_d.rsv_a = i_wr.data;
        `DCR_ADDR_RSV_B: state_d.rsv_b = i_wr.data;
        `DCR_ADDR_MASTER: state_d.master = i_wr.data;
        `DCR_ADDR_STAGE: state_d.stage = i_wr.data;
        `DCR_ADDR_SELBUF: state_d.selbuf = i_wr.data;
        `DCR_ADDR_PRESC: state_d.presc = i_wr.data;
        `DCR_ADDR_INTEG: state_d.integ = i_wr.data;
        `DCR_ADDR_PFD: state_d.pfd = i_wr.data;
        `DCR_ADDR_DEN_HI: state_d.den_hi = i_wr.data;
        `DCR_ADDR_DEN_LO: state_d.den_lo = i_wr.data;
        `DCR_ADDR_SEED_HI: state_d.seed_hi = i_wr.data;
        `DCR_ADDR_SEED_LO: state_d.seed_lo = i_wr.data;
        `DCR_ADDR_NUM_HI: state_d.num_hi = i_wr.data;
        `DCR_ADDR_NUM_LO: state_d.num_lo = i_wr.data;
        `DCR_ADDR_OUTA_SRC: state_d.outa_src = i_wr.data;
        `DCR_ADDR_OUTB_SRC: state_d.outb_src = i_wr.data;
        // writes to other addresses belong to other slices
        default: state_d.rsv_a = state_q.rsv_a;
      endcase
    end

    // read port shows the stored word one edge after the address
    state_d.rd_hit = 1'b1;
    unique case (i_rd_addr)
      `DCR_ADDR_INBUF: state_d.rd_data = state_q.inbuf;
      `DCR_ADDR_RSV_A: state_d.rd_data = state_q.rsv_a;
      `DCR_ADDR_RSV_B: state_d.rd_data = state_q.rsv_b;
      `DCR_ADDR_MASTER: state_d.rd_data = state_q.master;
      `DCR_ADDR_STAGE: state_d.rd_data = state_q.stage;
      `DCR_ADDR_SELBUF: state_d.rd_data = state_q.selbuf;
      `DCR_ADDR_PRESC: state_d.rd_data = state_q.presc;
      `DCR_ADDR_INTEG: state_d.rd_data = state_q.integ;
      `DCR_ADDR_PFD: state_d.rd_data = state_q.pfd;
      `DCR_ADDR_DEN_HI: state_d.rd_data = state_q.den_hi;
      `DCR_ADDR_DEN_LO: state_d.rd_data = state_q.den_lo;
      `DCR_ADDR_SEED_HI: state_d.rd_data = state_q.seed_hi;
      `DCR_ADDR_SEED_LO: state_d.rd_data = state_q.seed_lo;
      `DCR_ADDR_NUM_HI: state_d.rd_data = state_q.num_hi;
      `DCR_ADDR_NUM_LO: state_d.rd_data = state_q.num_lo;
      `DCR_ADDR_OUTA_SRC: state_d.rd_data = state_q.outa_src;
      `DCR_ADDR_OUTB_SRC: state_d.rd_data = state_q.outb_src;
      default: begin
        state_d.rd_data = 16'h0000;
        state_d.rd_hit = 1'b0;
      end
    endcase

    // decoded chain controls, from the stored words
    state_d.chain.enable_all = chain_en;
    state_d.chain.input_buf_on = input_on;
    state_d.chain.stage_on = stage_on & stage_used;
    state_d.chain.stage_one_ratio = stage_ratio[0];
    state_d.chain.stage_two_ratio = stage_ratio[1];
    state_d.chain.stage_three_ratio = stage_ratio[2];
    state_d.chain.active = chain_active;
    state_d.chain.total_ratio = chain_active ? total : 8'h00;
    state_d.chain.out_a_divided = out_divided[0];
    state_d.chain.out_b_divided = out_divided[1];
    state_d.chain.out_a_from_osc = out_from_osc[0];
    state_d.chain.out_b_from_osc = out_from_osc[1];

    // feedback divider setup
    state_d.fb.prescaler_ratio = state_q.presc[`DCR_BIT_PRESC] ?
      `DCR_PRESC_HIGH : `DCR_PRESC_LOW;
    state_d.fb.integer_part =
      state_q.integ[`DCR_MSB_INTEG:`DCR_LSB_INTEG];
    state_d.fb.numerator = {state_q.num_hi, state_q.num_lo};
    state_d.fb.denominator = {state_q.den_hi, state_q.den_lo};
    state_d.fb.seed = {state_q.seed_hi, state_q.seed_lo};
    // a zero denominator would make the fraction meaningless
    state_d.fb.fraction_valid =
      ({state_q.den_hi, state_q.den_lo} != 32'h0000_0000);
    state_d.fb.pfd_delay_cycles = pfd_cycles;
    state_d.fb.pfd_delay_valid = (pfd_cycles != 5'h00);
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      // each field is given its reset value exactly once
      state_q.inbuf <= `DCR_RST_ZERO;
      state_q.rsv_a <= `DCR_RST_ZERO;
      state_q.rsv_b <= `DCR_RST_ZERO;
      state_q.master <= `DCR_RST_MASTER;
      state_q.stage <= `DCR_RST_STAGE;
      state_q.selbuf <= `DCR_RST_SELBUF;
      state_q.presc <= `DCR_RST_ZERO;
      state_q.integ <= `DCR_RST_INTEG;
      state_q.pfd <= `DCR_RST_ZERO;
      state_q.den_hi <= `DCR_RST_DEN;
      state_q.den_lo <= `DCR_RST_DEN;
      state_q.seed_hi <= `DCR_RST_ZERO;
      state_q.seed_lo <= `DCR_RST_ZERO;
      state_q.num_hi <= `DCR_RST_ZERO;
      state_q.num_lo <= `DCR_RST_ZERO;
      state_q.outa_src <= `DCR_RST_ZERO;
      state_q.outb_src <= `DCR_RST_ZERO;
      state_q.rd_data <= `DCR_RST_ZERO;
      state_q.rd_hit <= 1'b0;
      // decoded outputs already match the reset words; stage enables
      // reset low, so the chain starts inactive
      state_q.chain.enable_all <= 1'b1;
      state_q.chain.input_buf_on <= 1'b1;
      state_q.chain.stage_on <= 3'h0;
      state_q.chain.stage_one_ratio <= 4'h3;
      state_q.chain.stage_two_ratio <= 4'h2;
      state_q.chain.stage_three_ratio <= 4'h2;
      state_q.chain.total_ratio <= 8'h00;
      state_q.chain.active <= 1'b0;
      state_q.chain.out_a_divided <= 1'b0;
      state_q.chain.out_b_divided <= 1'b0;
      state_q.chain.out_a_from_osc <= 1'b0;
      state_q.chain.out_b_from_osc <= 1'b0;
      state_q.fb.prescaler_ratio <= `DCR_PRESC_LOW;
      state_q.fb.integer_part <= 12'h01B;
      state_q.fb.numerator <= 32'h0000_0000;
      state_q.fb.denominator <= 32'h03E8_03E8;
      state_q.fb.seed <= 32'h0000_0000;
      state_q.fb.fraction_valid <= 1'b1;
      state_q.fb.pfd_delay_cycles <= 5'h00;
      state_q.fb.pfd_delay_valid <= 1'b0;
    end else if (i_clock_en) begin
      state_q <= state_d;
    end
  end

  assign o_rd_data = state_q.rd_data;
  assign o_rd_hit = state_q.rd_hit;
  assign o_chain = state_q.chain;
  assign o_feedback = state_q.fb;

endmodule

// *** verilog/dcr_pkg.sv ***
// Purpose: shared types of the divider configuration register slice
// Assumes: dcr_defines.svh supplies widths
// Notes: every carrier here is a packed struct
`include "dcr_defines.svh"

package dcr_pkg;

  typedef struct packed {
    logic valid;
    logic [`DCR_ADDR_W-1:0] addr;
    logic [`DCR_DATA_W-1:0] data;
  } dcr_wr_req_type;

  typedef struct packed {
    logic enable_all;
    logic input_buf_on;
    logic [2:0] stage_on;
    logic [3:0] stage_one_ratio;
    logic [3:0] stage_two_ratio;
    logic [3:0] stage_three_ratio;
    logic [7:0] total_ratio;
    logic active;
    logic out_a_divided;
    logic out_b_divided;
    logic out_a_from_osc;
    logic out_b_from_osc;
  } dcr_chain_type;

  typedef struct packed {
    logic [2:0] prescaler_ratio;
    logic [11:0] integer_part;
    logic [31:0] numerator;
    logic [31:0] denominator;
    logic [31:0] seed;
    logic fraction_valid;
    logic [4:0] pfd_delay_cycles;
    logic pfd_delay_valid;
  } dcr_feedback_type;

  typedef struct packed {
    logic [15:0] inbuf, rsv_a, rsv_b, master, stage, selbuf;
    logic [15:0] presc, integ, pfd, den_hi, den_lo, seed_hi;
    logic [15:0] seed_lo, num_hi, num_lo, outa_src, outb_src;
    logic [15:0] rd_data;
    logic rd_hit;
    dcr_chain_type chain;
    dcr_feedback_type fb;
  } dcr_state_type;

endpackage
